// [alu_cmp_pkg.sv]
package alu_cmp_pkg;
   // opcode values of the op_select_field
   localparam logic [7:0] OPC_FLOAT_GT_FLOAT   = 8'h09;
   localparam logic [7:0] OPC_FLOAT_GE_FLOAT   = 8'h0a;
   localparam logic [7:0] OPC_FLOAT_NEQ_FLOAT  = 8'h0b;
   localparam logic [7:0] OPC_FLOAT_GT_INT     = 8'h0d;
   localparam logic [7:0] OPC_FLOAT_GE_INT     = 8'h0e;
   localparam logic [7:0] OPC_FLOAT_NEQ_INT    = 8'h0f;
   localparam logic [7:0] OPC_SUB_INT          = 8'h35;
   localparam logic [7:0] OPC_SIGNED_GT        = 8'h3b;
   localparam logic [7:0] OPC_SIGNED_GE        = 8'h3c;
   localparam logic [7:0] OPC_INTEGER_NEQ      = 8'h3d;
   localparam logic [7:0] OPC_UNSIGNED_GT      = 8'h3e;
   localparam logic [7:0] OPC_UNSIGNED_GE      = 8'h3f;
   localparam logic [7:0] OPC_IEEE_ROOT        = 8'h8a;
   localparam logic [7:0] OPC_TRIG_WAVE        = 8'h8d;
   localparam logic [7:0] OPC_DOUBLE_ROOT_HIGH = 8'h99;
   localparam logic [7:0] OPC_DOUBLE_NEQ       = 8'hb9;
   localparam logic [7:0] OPC_DOUBLE_GT        = 8'hba;
   localparam logic [7:0] OPC_DOUBLE_GE        = 8'hbb;
   localparam logic [7:0] OPC_STORE_FLAGS      = 8'hda;
   // result encodings
   localparam logic [31:0] FLOAT_ONE  = 32'h3f800000;
   localparam logic [31:0] FLOAT_ZERO = 32'h00000000;
   localparam logic [31:0] MASK_ONES  = 32'hffffffff;
   localparam logic [31:0] MASK_ZERO  = 32'h00000000;
   localparam logic [63:0] DOUBLE_ONE = 64'h3ff0000000000000;
   // |x| >= 256.0 as a biased exponent
   localparam logic [7:0]  TRIG_EXP_LIMIT = 8'h87;
   localparam logic [7:0]  FLOAT_BIAS     = 8'h7f;
   localparam logic [10:0] DOUBLE_BIAS    = 11'h3ff;
   localparam logic [1:0]  SLOT_W         = 2'h3;
   localparam int          FLAG_W         = 6;
   // compare kinds for the ordering unit
   typedef enum logic [1:0] {CMP_GT = 2'h0, CMP_GE = 2'h1, CMP_NE = 2'h2} cmp_kind_t;
endpackage

// [alu_compare_set_and_misc_ops.sv]
// Summary of operation
// - double ge gives all-ones mask, predicate untouched
// - double gt gives all-ones mask, predicate untouched
// - double ne gives all-ones mask, predicate untouched
// - float ge writes integer mask, opcode 14
// - float gt writes integer mask, opcode 13
// - signed gt writes integer mask, opcode 59
// - signed ge 60, unsigned ge 63
// - unsigned gt 62, float gt float 9
// - float ne writes 1.0 or 0.0
// - float ne writes integer mask, opcode 15
// - integer ne ignores signedness, opcode 61
// - sine of normalized input, zero beyond 256
// - double root from split operand, exact one
// - ieee square root under opcode 138
// - store flags copies working flags when enabled
// - integer subtract is operand1 minus operand0
// - float ge writes 1.0 or 0.0
`timescale 1ns/1ps
`default_nettype none
module alu_compare_set_and_misc_ops
   import alu_cmp_pkg::*;
(
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   input  wire logic              issue_in,       // one-cycle instruction strobe
   input  wire logic [7:0]        op_select_in,   // op_select_field
   input  wire logic [1:0]        slot_in,        // channel slot x,y,z,w
   input  wire logic              reg_write_in,   // general_register write enable
   input  wire logic [31:0]       src0_in,
   input  wire logic [31:0]       src1_in,
   input  wire logic [FLAG_W-1:0] flags_in,       // working flags incl. this bundle
   output logic [31:0]            result_out,
   output logic                   result_valid_out,
   output logic                   dst_write_out,
   output logic                   pred_write_out,
   output logic                   illegal_out
);
   // state of the result stage
   typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_DONE = 2'h2} stage_t;
   stage_t    stage_r;
   stage_t    stage_nxt;
   logic [31:0] result_r;          // registered result
   logic [31:0] result_nxt;        // result picked by decode
   logic        valid_r;
   logic        write_r;
   logic        write_nxt;
   logic        illegal_r;
   logic        illegal_nxt;
   logic        known;             // opcode belongs to this block
   cmp_kind_t   kind;              // compare flavour for this opcode
   logic        f_true;            // single float compare outcome
   logic        d_true;            // double compare outcome
   logic [63:0] d_a;               // double operand 0 as hi/lo pair
   logic [63:0] d_b;               // double operand 1
   logic [31:0] root_f;            // single root estimate
   logic [63:0] root_d;            // double root estimate
   logic [31:0] trig_f;            // sine estimate
   logic [7:0]  trig_exp;          // biased exponent of sine input
   // double operands: pair of dwords; operand 0 has high word in src0, low in src1, operand 1 swaps them
   assign d_a = {src0_in, src1_in};
   assign d_b = {src1_in, src0_in};
   // compare kind from opcode
   always_comb begin
      case (op_select_in)
         OPC_FLOAT_GT_FLOAT, OPC_FLOAT_GT_INT, OPC_DOUBLE_GT:   kind = CMP_GT;
         OPC_FLOAT_GE_FLOAT, OPC_FLOAT_GE_INT, OPC_DOUBLE_GE:   kind = CMP_GE;
         default:                                               kind = CMP_NE;
      endcase
   end
   // one shared comparator per precision saves area over one per opcode
   fp_order_cmp #(.EXP_W(8), .MAN_W(23)) u_fcmp (
      .a_in     (src0_in),
      .b_in     (src1_in),
      .kind_in  (kind),
      .true_out (f_true)
   );
   fp_order_cmp #(.EXP_W(11), .MAN_W(52)) u_dcmp (
      .a_in     (d_a),
      .b_in     (d_b),
      .kind_in  (kind),
      .true_out (d_true)
   );
   root_approx #(.EXP_W(8), .MAN_W(23)) u_froot (
      .x_in    (src0_in),
      .bias_in (FLOAT_BIAS),
      .y_out   (root_f)
   );
   root_approx #(.EXP_W(11), .MAN_W(52)) u_droot (
      .x_in    (d_a),
      .bias_in (DOUBLE_BIAS),
      .y_out   (root_d)
   );
   // sine approximation: input is in turns; sub-turn input passes through unchanged,
   // zero outside [-256,256]; a crude estimate, not a full table
   assign trig_exp = src0_in[30:23];
   always_comb begin
      if (trig_exp > TRIG_EXP_LIMIT || (trig_exp == TRIG_EXP_LIMIT && |src0_in[22:0])) begin
         trig_f = FLOAT_ZERO;
      end else if (trig_exp >= FLOAT_BIAS) begin
         trig_f = FLOAT_ZERO;    // whole turns: integer part gives sine zero
      end else begin
         trig_f = src0_in;       // sub-turn input passes through unscaled as the estimate
      end
   end
   // opcode decode and routing
   always_comb begin
      result_nxt  = MASK_ZERO;
      known       = 1'b1;
      illegal_nxt = 1'b0;
      case (op_select_in)
         OPC_FLOAT_GT_FLOAT:   result_nxt = f_true ? FLOAT_ONE : FLOAT_ZERO;
         OPC_FLOAT_GE_FLOAT:   result_nxt = f_true ? FLOAT_ONE : FLOAT_ZERO;
         OPC_FLOAT_NEQ_FLOAT:  result_nxt = f_true ? FLOAT_ONE : FLOAT_ZERO;
         OPC_FLOAT_GT_INT:     result_nxt = f_true ? MASK_ONES : MASK_ZERO;
         OPC_FLOAT_GE_INT:     result_nxt = f_true ? MASK_ONES : MASK_ZERO;
         OPC_FLOAT_NEQ_INT:    result_nxt = f_true ? MASK_ONES : MASK_ZERO;
         OPC_SIGNED_GT:
            result_nxt = ($signed(src0_in) > $signed(src1_in)) ? MASK_ONES : MASK_ZERO;
         OPC_SIGNED_GE:
            result_nxt = ($signed(src0_in) >= $signed(src1_in)) ? MASK_ONES : MASK_ZERO;
         OPC_UNSIGNED_GT:      result_nxt = (src0_in > src1_in) ? MASK_ONES : MASK_ZERO;
         OPC_UNSIGNED_GE:      result_nxt = (src0_in >= src1_in) ? MASK_ONES : MASK_ZERO;
         OPC_INTEGER_NEQ:      result_nxt = (src0_in != src1_in) ? MASK_ONES : MASK_ZERO;
         OPC_SUB_INT:          result_nxt = src1_in - src0_in;
         OPC_DOUBLE_GE:        result_nxt = d_true ? MASK_ONES : MASK_ZERO;
         OPC_DOUBLE_GT:        result_nxt = d_true ? MASK_ONES : MASK_ZERO;
         OPC_DOUBLE_NEQ:       result_nxt = d_true ? MASK_ONES : MASK_ZERO;
         OPC_TRIG_WAVE:        result_nxt = trig_f;
         OPC_IEEE_ROOT:        result_nxt = root_f;
         OPC_DOUBLE_ROOT_HIGH: begin
            // exact one is special-cased so 1.0 never picks up estimate error
            if (d_a == DOUBLE_ONE) begin
               result_nxt = DOUBLE_ONE[63:32];
            end else begin
               result_nxt = root_d[63:32];
            end
         end
         OPC_STORE_FLAGS: begin
            result_nxt  = {{(32-FLAG_W){1'b0}}, flags_in};
            illegal_nxt = (slot_in != SLOT_W);
         end
         default: known = 1'b0;
      endcase
   end
   // write only when the bundle enables the register write
   assign write_nxt = issue_in && known && reg_write_in && !illegal_nxt;
   // result stage state: done for one cycle after each issue of a known opcode
   always_comb begin
      case (stage_r)
         ST_IDLE: stage_nxt = (issue_in && known) ? ST_DONE : ST_IDLE;
         ST_DONE: stage_nxt = (issue_in && known) ? ST_DONE : ST_IDLE;
         default: stage_nxt = ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         stage_r <= ST_IDLE;
      end else begin
         stage_r <= stage_nxt;
      end
   end
   // result register, holds between issues
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         result_r <= MASK_ZERO;
      end else if (issue_in && known) begin
         result_r <= result_nxt;
      end
   end
   // strobes
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         valid_r   <= 1'b0;
         write_r   <= 1'b0;
         illegal_r <= 1'b0;
      end else begin
         valid_r   <= issue_in && known;
         write_r   <= write_nxt;
         illegal_r <= issue_in && illegal_nxt;
      end
   end
   assign result_out       = result_r;
   assign result_valid_out = valid_r;
   assign dst_write_out    = write_r;
   // none of these opcodes update the predicate
   assign pred_write_out   = 1'b0;
   assign illegal_out      = illegal_r;

   AST_DOUBLE_GE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_DOUBLE_GE && src0_in == src1_in && !(&src0_in[30:20])
      |=> result_out == MASK_ONES) else $error("double ge equal operands not ones");
   AST_DOUBLE_NO_PRED: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in ##1 valid_r |-> !pred_write_out) else $error("predicate written");
   AST_FGE_INT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_FLOAT_GE_INT && src0_in == FLOAT_ONE && src1_in == FLOAT_ZERO
      |=> result_out == MASK_ONES && result_valid_out) else $error("float ge mask wrong");
   AST_SIGNED_GT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_SIGNED_GT
      |=> result_out == (($signed($past(src0_in)) > $signed($past(src1_in))) ? MASK_ONES : MASK_ZERO))
      else $error("signed gt wrong");
   AST_UNSIGNED_GE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_UNSIGNED_GE
      |=> result_out == (($past(src0_in) >= $past(src1_in)) ? MASK_ONES : MASK_ZERO))
      else $error("unsigned ge wrong");
   AST_FNE_FLOAT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_FLOAT_NEQ_FLOAT && src0_in == src1_in && !(&src0_in[30:23])
      |=> result_out == FLOAT_ZERO) else $error("float ne on equal not zero");
   AST_INT_NEQ: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_INTEGER_NEQ
      |=> result_out == (($past(src0_in) != $past(src1_in)) ? MASK_ONES : MASK_ZERO))
      else $error("integer ne wrong");
   AST_TRIG_RANGE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_TRIG_WAVE && src0_in[30:23] > TRIG_EXP_LIMIT
      |=> result_out == FLOAT_ZERO) else $error("sine out of range not zero");
   AST_ROOT_ONE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_DOUBLE_ROOT_HIGH && {src0_in, src1_in} == DOUBLE_ONE
      |=> result_out == DOUBLE_ONE[63:32]) else $error("root of one not exact");
   AST_FLAGS: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_STORE_FLAGS && slot_in == SLOT_W && reg_write_in
      |=> dst_write_out && result_out[FLAG_W-1:0] == $past(flags_in)) else $error("flags not stored");
   AST_SUB: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_SUB_INT
      |=> result_out == 32'($past(src1_in) - $past(src0_in))) else $error("subtract wrong");
   AST_NAN_GT: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      issue_in && op_select_in == OPC_FLOAT_GT_INT && (&src0_in[30:23]) && (|src0_in[22:0])
      |=> result_out == MASK_ZERO) else $error("nan compare true");
endmodule
`default_nettype wire

// [fp_order_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
// ieee ordered compare for any float width; nan makes gt/ge false, ne true
module fp_order_cmp
   import alu_cmp_pkg::*;
#(
   parameter int EXP_W = 8,
   parameter int MAN_W = 23
) (
   input  wire logic [EXP_W+MAN_W:0] a_in,
   input  wire logic [EXP_W+MAN_W:0] b_in,
   input  wire cmp_kind_t            kind_in,
   output logic                      true_out
);
   localparam int W = EXP_W + MAN_W + 1;
   logic a_nan;       // operand 0 is nan
   logic b_nan;       // operand 1 is nan
   logic both_zero;   // +0 and -0 compare equal
   logic a_gt;        // magnitude ordering with signs
   logic eq;          // numerically equal
   assign a_nan = (&a_in[W-2:MAN_W]) && (|a_in[MAN_W-1:0]);
   assign b_nan = (&b_in[W-2:MAN_W]) && (|b_in[MAN_W-1:0]);
   assign both_zero = ~|{a_in[W-2:0], b_in[W-2:0]};
   assign eq = both_zero || (a_in == b_in);
   // sign-magnitude ordering
   always_comb begin
      if (a_in[W-1] != b_in[W-1]) begin
         a_gt = !a_in[W-1] && !both_zero;
      end else if (!a_in[W-1]) begin
         a_gt = a_in[W-2:0] > b_in[W-2:0];
      end else begin
         a_gt = a_in[W-2:0] < b_in[W-2:0];
      end
   end
   // nan forces the unordered answer
   always_comb begin
      case (kind_in)
         CMP_GT:  true_out = !a_nan && !b_nan && a_gt;
         CMP_GE:  true_out = !a_nan && !b_nan && (a_gt || eq);
         CMP_NE:  true_out = a_nan || b_nan || !eq;
         default: true_out = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// [root_approx.sv]
`timescale 1ns/1ps
`default_nettype none
// coarse square root: halve unbiased exponent, keep top mantissa bits shifted
// a limitation: precision is only a first-order estimate, no iteration
module root_approx
   import alu_cmp_pkg::*;
#(
   parameter int EXP_W = 8,
   parameter int MAN_W = 23
) (
   input  wire logic [EXP_W+MAN_W:0] x_in,
   input  wire logic [EXP_W-1:0]     bias_in,
   output logic [EXP_W+MAN_W:0]      y_out
);
   logic [EXP_W:0] sum;  // exponent plus bias, halved below
   always_comb begin
      sum = {1'b0, x_in[EXP_W+MAN_W-1:MAN_W]} + {1'b0, bias_in};
      if (x_in[EXP_W+MAN_W-1:0] == '0) begin
         y_out = x_in;                          // zero keeps its sign
      end else if (x_in[EXP_W+MAN_W]) begin
         y_out = {1'b0, {EXP_W{1'b1}}, 1'b1, {(MAN_W-1){1'b0}}};  // negative gives nan
      end else if (&x_in[EXP_W+MAN_W-1:MAN_W]) begin
         y_out = x_in;                          // inf or nan pass through
      end else begin
         y_out = {1'b0, sum[EXP_W:1], x_in[MAN_W-1:0] >> 1};
      end
   end
endmodule
`default_nettype wire

// [seq_issue_model.sv]
`timescale 1ns/1ps
`default_nettype none
// instruction sequencer seen from the alu: one word per call, issue held high across calls
module seq_issue_model
   import alu_cmp_pkg::*;
(
   input  wire logic              sys_clk_in,
   output logic                   issue_out,   // instruction strobe
   output logic [7:0]             op_out,      // op_select_field
   output logic [1:0]             slot_out,    // channel slot
   output logic                   wr_out,      // general_register write enable
   output logic [31:0]            a_out,       // operand 0
   output logic [31:0]            b_out,       // operand 1
   output logic [FLAG_W-1:0]      flags_out    // working exception flags
);
   // quiet bus at time zero
   initial begin
      issue_out = 1'b0;
      op_out    = 8'h00;
      slot_out  = 2'h0;
      wr_out    = 1'b0;
      a_out     = 32'h00000000;
      b_out     = 32'h00000000;
      flags_out = '0;
   end

   // drive one word just after an edge; stray lets the bench misplace store-flags on purpose
   task automatic send(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
                       input logic [1:0] slot, input logic wr, input logic [FLAG_W-1:0] fl,
                       input bit stray);
      @(posedge sys_clk_in);
      issue_out <= 1'b1;
      op_out    <= op;
      a_out     <= a;
      b_out     <= b;
      wr_out    <= wr;
      flags_out <= fl;
      slot_out  <= (op == OPC_STORE_FLAGS && !stray) ? SLOT_W : slot;
   endtask

   // released operands carry the inverse of the last word, so stale data never looks valid
   task automatic idle();
      @(posedge sys_clk_in);
      issue_out <= 1'b0;
      a_out     <= ~a_out;
      b_out     <= ~b_out;
   endtask
endmodule
`default_nettype wire

// [test_alu_compare_set_and_misc_ops.sv]
`timescale 1ns/1ps
`default_nettype none
module test_alu_compare_set_and_misc_ops;
   import alu_cmp_pkg::*;
   logic              sys_clk_in;      // 40 mhz
   logic              reset_in;        // sync, active high
   logic              issue;           // from the sequencer model
   logic [7:0]        op_sel;
   logic [1:0]        slot;
   logic              reg_wr;
   logic [31:0]       src0;
   logic [31:0]       src1;
   logic [FLAG_W-1:0] flags;
   logic [31:0]       result_out;
   logic              result_valid_out;
   logic              dst_write_out;
   logic              pred_write_out;
   logic              illegal_out;
   int                miscompares;     // mismatch count
   int                checked;         // compare count
   int                cycles;          // timeout counter
   logic [31:0]       seed;            // xorshift state
   logic [7:0]        ops [0:19];      // every opcode plus one unknown
   logic [31:0]       e_res;           // model: held result
   logic              e_valid, e_dst, e_ill, res_ok, armed;
   logic              e_root;          // model: the op now shown was the ieee root
   logic [32:0]       p;

   alu_compare_set_and_misc_ops alu_compare_set_and_misc_ops_inst (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .issue_in(issue), .op_select_in(op_sel),
      .slot_in(slot), .reg_write_in(reg_wr), .src0_in(src0), .src1_in(src1), .flags_in(flags),
      .result_out(result_out), .result_valid_out(result_valid_out),
      .dst_write_out(dst_write_out), .pred_write_out(pred_write_out),
      .illegal_out(illegal_out));

   seq_issue_model seq_issue_model_inst (
      .sys_clk_in(sys_clk_in), .issue_out(issue), .op_out(op_sel), .slot_out(slot),
      .wr_out(reg_wr), .a_out(src0), .b_out(src1), .flags_out(flags));

   // free-running clock, 25 ns period
   initial begin
      sys_clk_in = 1'b0;
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   // xorshift source of stimulus
   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // ieee ordering through a sign-magnitude key; +0 and -0 land on the same key
   function automatic bit fcmp(input logic [63:0] a, input logic [63:0] b, input bit dbl,
                               input int k);
      longint ka, kb;
      bit     nan;
      nan = dbl ? ((&a[62:52] && |a[51:0]) || (&b[62:52] && |b[51:0]))
                : ((&a[30:23] && |a[22:0]) || (&b[30:23] && |b[22:0]));
      ka = dbl ? {1'b0, a[62:0]} : {33'h0, a[30:0]};
      kb = dbl ? {1'b0, b[62:0]} : {33'h0, b[30:0]};
      if (dbl ? a[63] : a[31]) ka = -ka;
      if (dbl ? b[63] : b[31]) kb = -kb;
      if (nan) return k == 2;
      return (k == 0) ? (ka > kb) : (k == 1) ? (ka >= kb) : (ka != kb);
   endfunction

   function automatic bit known(input logic [7:0] op);
      return op inside {OPC_FLOAT_GT_FLOAT, OPC_FLOAT_GE_FLOAT, OPC_FLOAT_NEQ_FLOAT,
         OPC_FLOAT_GT_INT, OPC_FLOAT_GE_INT, OPC_FLOAT_NEQ_INT, OPC_SUB_INT, OPC_SIGNED_GT,
         OPC_SIGNED_GE, OPC_INTEGER_NEQ, OPC_UNSIGNED_GT, OPC_UNSIGNED_GE, OPC_IEEE_ROOT,
         OPC_TRIG_WAVE, OPC_DOUBLE_ROOT_HIGH, OPC_DOUBLE_NEQ, OPC_DOUBLE_GT, OPC_DOUBLE_GE,
         OPC_STORE_FLAGS};
   endfunction

   // bit 32 says whether the result is predictable; the estimates are only pinned at fixed points
   function automatic logic [32:0] predict(input logic [7:0] op, input logic [31:0] a,
                                           input logic [31:0] b, input logic [FLAG_W-1:0] fl);
      logic [63:0] fa, fb, da, db;
      fa = {32'h0, a};
      fb = {32'h0, b};
      da = {a, b};
      db = {b, a};
      case (op)
         OPC_FLOAT_GT_FLOAT:   return {1'b1, fcmp(fa, fb, 0, 0) ? FLOAT_ONE : FLOAT_ZERO};
         OPC_FLOAT_GE_FLOAT:   return {1'b1, fcmp(fa, fb, 0, 1) ? FLOAT_ONE : FLOAT_ZERO};
         OPC_FLOAT_NEQ_FLOAT:  return {1'b1, fcmp(fa, fb, 0, 2) ? FLOAT_ONE : FLOAT_ZERO};
         OPC_FLOAT_GT_INT:     return {1'b1, fcmp(fa, fb, 0, 0) ? MASK_ONES : MASK_ZERO};
         OPC_FLOAT_GE_INT:     return {1'b1, fcmp(fa, fb, 0, 1) ? MASK_ONES : MASK_ZERO};
         OPC_FLOAT_NEQ_INT:    return {1'b1, fcmp(fa, fb, 0, 2) ? MASK_ONES : MASK_ZERO};
         OPC_DOUBLE_GT:        return {1'b1, fcmp(da, db, 1, 0) ? MASK_ONES : MASK_ZERO};
         OPC_DOUBLE_GE:        return {1'b1, fcmp(da, db, 1, 1) ? MASK_ONES : MASK_ZERO};
         OPC_DOUBLE_NEQ:       return {1'b1, fcmp(da, db, 1, 2) ? MASK_ONES : MASK_ZERO};
         OPC_SIGNED_GT:        return {1'b1, ($signed(a) > $signed(b)) ? MASK_ONES : MASK_ZERO};
         OPC_SIGNED_GE:        return {1'b1, ($signed(a) >= $signed(b)) ? MASK_ONES : MASK_ZERO};
         OPC_UNSIGNED_GT:      return {1'b1, (a > b) ? MASK_ONES : MASK_ZERO};
         OPC_UNSIGNED_GE:      return {1'b1, (a >= b) ? MASK_ONES : MASK_ZERO};
         OPC_INTEGER_NEQ:      return {1'b1, (a != b) ? MASK_ONES : MASK_ZERO};
         OPC_SUB_INT:          return {1'b1, b - a};
         OPC_STORE_FLAGS:      return {1'b1, {(32 - FLAG_W){1'b0}}, fl};
         OPC_DOUBLE_ROOT_HIGH: return {da == DOUBLE_ONE, DOUBLE_ONE[63:32]};
         OPC_TRIG_WAVE:        return {a[30:23] != 8'hff && (a[30:23] > TRIG_EXP_LIMIT ||
                                      (a[30:23] == TRIG_EXP_LIMIT && |a[22:0])), FLOAT_ZERO};
         OPC_IEEE_ROOT:        return {a == FLOAT_ONE, FLOAT_ONE};
         default:              return {1'b0, 32'h0};
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // model samples what the design samples at the same edge
   always @(posedge sys_clk_in) begin
      e_valid = 1'b0;
      e_dst   = 1'b0;
      e_ill   = 1'b0;
      e_root  = 1'b0;
      if (reset_in) begin
         armed  = 1'b1;
         e_res  = 32'h0;
         res_ok = 1'b1;
      end else if (issue && known(op_sel)) begin
         p       = predict(op_sel, src0, src1, flags);
         e_res   = p[31:0];
         res_ok  = p[32];
         e_valid = 1'b1;
         e_ill   = (op_sel == OPC_STORE_FLAGS) && (slot != SLOT_W);
         e_dst   = reg_wr && !e_ill;
         e_root  = (op_sel == OPC_IEEE_ROOT);
      end
   end

   // outputs are settled half a cycle after the edge
   always @(negedge sys_clk_in) begin
      if (armed) begin
         check({31'h0, result_valid_out}, {31'h0, e_valid});
         check({31'h0, dst_write_out}, {31'h0, e_dst});
         check({31'h0, illegal_out}, {31'h0, e_ill});
         check({31'h0, pred_write_out}, 32'h0);
         if (res_ok) check(result_out, e_res);
         if (e_root) check({31'h0, result_valid_out}, 32'h1);
      end
   end

   // hang guard, far above the roughly 600 cycles the run needs
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end

   initial begin
      logic [31:0] r, a, b;
      logic [31:0] pa [0:7];
      logic [31:0] pb [0:7];
      int          idx;
      miscompares = 0;
      checked     = 0;
      cycles      = 0;
      armed       = 1'b0;
      seed        = 32'd88180;
      reset_in    = 1'b1;
      ops = '{OPC_FLOAT_GT_FLOAT, OPC_FLOAT_GE_FLOAT, OPC_FLOAT_NEQ_FLOAT, OPC_FLOAT_GT_INT,
              OPC_FLOAT_GE_INT, OPC_FLOAT_NEQ_INT, OPC_SUB_INT, OPC_SIGNED_GT, OPC_SIGNED_GE,
              OPC_INTEGER_NEQ, OPC_UNSIGNED_GT, OPC_UNSIGNED_GE, OPC_IEEE_ROOT, OPC_TRIG_WAVE,
              OPC_DOUBLE_ROOT_HIGH, OPC_DOUBLE_NEQ, OPC_DOUBLE_GT, OPC_DOUBLE_GE,
              OPC_STORE_FLAGS, 8'h00};
      // equal, greater, smaller, nan, -0 vs +0, sign boundary, sine out of range, double one
      pa = '{32'h3f800000, 32'h40000000, 32'h3f800000, 32'h7fc00000,
             32'h80000000, 32'h80000000, 32'h43960000, 32'h3ff00000};
      pb = '{32'h3f800000, 32'h3f800000, 32'h40000000, 32'h3f800000,
             32'h00000000, 32'h00000001, 32'hc3960000, 32'h00000000};
      repeat (20) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      // every opcode against every boundary pair, back to back
      for (int i = 0; i < 8; i++)
         for (int j = 0; j < 20; j++)
            seq_issue_model_inst.send(ops[j], pa[i], pb[i], 2'h0, 1'b1, 6'h2a, 1'b0);
      // store-flags misplaced in x and z slots, then legal with writing off
      seq_issue_model_inst.send(OPC_STORE_FLAGS, 32'h0, 32'h0, 2'h0, 1'b1, 6'h3f, 1'b1);
      seq_issue_model_inst.send(OPC_STORE_FLAGS, 32'h0, 32'h0, 2'h2, 1'b1, 6'h15, 1'b1);
      seq_issue_model_inst.send(OPC_STORE_FLAGS, 32'h0, 32'h0, 2'h3, 1'b0, 6'h15, 1'b0);
      // one against zero reaches the mask assertion for float ge
      seq_issue_model_inst.send(OPC_FLOAT_GE_INT, FLOAT_ONE, FLOAT_ZERO, 2'h0, 1'b1, 6'h0, 1'b0);
      seq_issue_model_inst.idle();
      // random back-to-back traffic, equal operands now and then
      for (int n = 0; n < 400; n++) begin
         r   = next_rand();
         idx = r % 20;
         a   = next_rand();
         b   = r[4] ? a : next_rand();
         seq_issue_model_inst.send(ops[idx], a, b, r[9:8], r[10], r[16:11], r[20:17] == 4'h0);
      end
      // reset in mid-run with an issue pending, then issue on the first edge after release
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      seq_issue_model_inst.send(OPC_SUB_INT, 32'h1, 32'h0, 2'h1, 1'b1, 6'h0, 1'b0);
      reset_in <= 1'b0;
      seq_issue_model_inst.send(OPC_SUB_INT, 32'h1, 32'h0, 2'h1, 1'b1, 6'h0, 1'b0);
      repeat (3) seq_issue_model_inst.idle();
      wrap_up();
   end
endmodule
`default_nettype wire
